// file: hw/pcg_consts.vh
// Purpose: constants of the peripheral clock gating block
// Assumes: 32-bit register port, word offsets as byte addresses
// Notes: included by every design file of the block
//
// Functional notes
// [R1] each implemented gating bit enables one unit clock; zero stops and disables it
// [R2] access to a unit whose clock is gated off ends in a bus fault
// [R3] gating bits reset to zero except hibernation; registers reset to 0x00000040
// [R4] 0x100 governs run, 0x110 sleep, a third register deep sleep
// [R5] sleep registers apply in sleep modes only when sleep gating select is set
// [R6] bit 24 gates can unit zero, read/write, resets to zero
// [R7] bit 6 gates hibernation module, read/write, resets to one
// [R8] bit 3 gates watchdog, resets to zero; gated-off watchdog access faults
// [R9] reserved bits are read-only and read as zero
// [R10] registers sit in system control space at base 0x400F_E000
// [R11] software enables every needed unit before using it
// [R12] deep sleep register at 0x120 with same layout and reset value
// [R13] with select clear, run register governs sleep and deep sleep too
`ifndef PCG_CONSTS_VH
`define PCG_CONSTS_VH
`define PCG_BASE_ADDR 32'h400F_E000
`define PCG_OFS_RUN 12'h100
`define PCG_OFS_SLP 12'h110
`define PCG_OFS_DSL 12'h120
`define PCG_OFS_CFG 12'h130
`define PCG_OFS_IST 12'h140
`define PCG_OFS_IMSK 12'h144
`define PCG_GATE_RESET 32'h0000_0040
`define PCG_GATE_MASK 32'h0100_0048
`define PCG_BIT_CAN 24
`define PCG_BIT_HIB 6
`define PCG_BIT_WDT 3
`define PCG_BIT_SELECT 0
`define PCG_NUM_UNITS 3
`define PCG_MODE_RUN 2'h0
`define PCG_MODE_SLEEP 2'h1
`define PCG_MODE_DEEP 2'h2
`endif

// file: hw/pcg_gate_reg.v
// Purpose: one 32-bit gating register with read-only reserved bits
// Assumes: write strobe already decoded for this register
// Notes: only bits in the implemented mask are stored
`timescale 1ns/100ps
`default_nettype none
`include "pcg_consts.vh"
module pcg_gate_reg (
   input wire ref_clk,
   input wire rst,
   input wire wr_en,
   input wire [31:0] wr_data,
   output wire [31:0] value
);
   reg [31:0] gate_q;
   // reserved bits never store, so they always read zero
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gate_q <= `PCG_GATE_RESET; // [R3]
      end else if (wr_en) begin
         gate_q <= wr_data & `PCG_GATE_MASK; // [R9]
      end
   end
   assign value = gate_q;
endmodule // pcg_gate_reg
`default_nettype wire

// file: hw/pcg_fault_check.v
// Purpose: bus fault decision for accesses to the gated units
// Assumes: unit select and strobes on the same clock as the gates
// Notes: purely combinational, registered by the top
`timescale 1ns/100ps
`default_nettype none
`include "pcg_consts.vh"
module pcg_fault_check (
   input wire [`PCG_NUM_UNITS-1:0] unit_sel,
   input wire [`PCG_NUM_UNITS-1:0] unit_clk_en,
   input wire unit_rd,
   input wire unit_wr,
   output wire [`PCG_NUM_UNITS-1:0] fault
);
   genvar i;
   // one fault term per unit; access to a stopped unit faults
   generate
      for (i = 0; i < `PCG_NUM_UNITS; i = i + 1) begin : g_unit
         assign fault[i] = unit_sel[i] & (unit_rd | unit_wr) & ~unit_clk_en[i]; // [R2] [R8]
      end
   endgenerate
endmodule // pcg_fault_check
`default_nettype wire

// file: hw/pcg_top.v
// Purpose: per-unit clock gating for can unit zero, hibernation and watchdog
// Assumes: single clock ref_clk 200 MHz, asynchronous active-high rst
// Notes: unit index 0 watchdog, 1 hibernation, 2 can unit zero
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "pcg_consts.vh"
module pcg_top (
   input wire ref_clk,
   input wire rst,
   input wire [11:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire [1:0] power_mode,
   input wire [2:0] unit_sel,
   input wire unit_rd,
   input wire unit_wr,
   output reg [2:0] unit_clk_en,
   output reg [2:0] unit_fault,
   output reg irq
);
   wire [31:0] run_gate;
   wire [31:0] slp_gate;
   wire [31:0] dsl_gate;
   wire [2:0] fault_now;
   reg [1:0] mode_meta_q;
   reg [1:0] mode_q;
   reg select_q;
   reg [2:0] ist_q;
   reg [2:0] imsk_q;
   reg [31:0] active_gate;
   reg [31:0] rdata_d;
   wire wr_run;
   wire wr_slp;
   wire wr_dsl;

   // power mode comes from the processor core domain, so synchronise it
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_meta_q <= `PCG_MODE_RUN;
         mode_q <= `PCG_MODE_RUN;
      end else begin
         mode_meta_q <= power_mode;
         mode_q <= mode_meta_q;
      end
   end

   // write decode, offsets relative to system control base
   assign wr_run = reg_wr && (reg_addr == `PCG_OFS_RUN); // [R4] [R10]
   assign wr_slp = reg_wr && (reg_addr == `PCG_OFS_SLP); // [R4]
   assign wr_dsl = reg_wr && (reg_addr == `PCG_OFS_DSL); // [R12]

   pcg_gate_reg u_run (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(wr_run),
      .wr_data(reg_wdata),
      .value(run_gate)
   );
   pcg_gate_reg u_slp (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(wr_slp),
      .wr_data(reg_wdata),
      .value(slp_gate)
   );
   pcg_gate_reg u_dsl (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(wr_dsl),
      .wr_data(reg_wdata),
      .value(dsl_gate)
   );

   // sleep gating select bit, clear after reset
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         select_q <= 1'b0;
      end else if (reg_wr && (reg_addr == `PCG_OFS_CFG)) begin
         select_q <= reg_wdata[`PCG_BIT_SELECT];
      end
   end

   // pick the register that governs the present power mode
   always @* begin
      active_gate = run_gate; // [R13]
      if (select_q) begin // [R5]
         case (mode_q)
            `PCG_MODE_SLEEP: active_gate = slp_gate; // [R4]
            `PCG_MODE_DEEP: active_gate = dsl_gate; // [R12]
            default: active_gate = run_gate;
         endcase
      end
   end

   // clock enables registered so units see glitch-free gates
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         unit_clk_en <= 3'h2; // [R3] [R7]
      end else begin
         unit_clk_en[0] <= active_gate[`PCG_BIT_WDT]; // [R1] [R8]
         unit_clk_en[1] <= active_gate[`PCG_BIT_HIB]; // [R1] [R7]
         unit_clk_en[2] <= active_gate[`PCG_BIT_CAN]; // [R1] [R6]
      end
   end

   pcg_fault_check u_fault (
      .unit_sel(unit_sel),
      .unit_clk_en(unit_clk_en),
      .unit_rd(unit_rd),
      .unit_wr(unit_wr),
      .fault(fault_now)
   );

   // fault answer one cycle after the access
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         unit_fault <= 3'h0;
      end else begin
         unit_fault <= fault_now; // [R2]
      end
   end

   // sticky fault status: set wins over write-one-to-clear
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ist_q <= 3'h0;
         imsk_q <= 3'h0;
      end else begin
         if (reg_wr && (reg_addr == `PCG_OFS_IST)) begin
            ist_q <= (ist_q & ~reg_wdata[2:0]) | fault_now;
         end else begin
            ist_q <= ist_q | fault_now;
         end
         if (reg_wr && (reg_addr == `PCG_OFS_IMSK)) begin
            imsk_q <= reg_wdata[2:0];
         end
      end
   end

   // level interrupt from flop; lags status by one cycle
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ist_q & imsk_q);
      end
   end

   // read mux; unmapped offsets read zero
   always @* begin
      case (reg_addr)
         `PCG_OFS_RUN: rdata_d = run_gate; // [R9]
         `PCG_OFS_SLP: rdata_d = slp_gate;
         `PCG_OFS_DSL: rdata_d = dsl_gate;
         `PCG_OFS_CFG: rdata_d = {31'h0000_0000, select_q};
         `PCG_OFS_IST: rdata_d = {29'h0000_0000, ist_q};
         `PCG_OFS_IMSK: rdata_d = {29'h0000_0000, imsk_q};
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   // read data valid only in the cycle after the strobe
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end
endmodule // pcg_top
`default_nettype wire

// file: tb/pcg_monitor.sv
// Purpose: port checks of pcg_top; Assumes: one clock; Notes: bound at foot
`timescale 1ns/100ps
`default_nettype none
module pcg_monitor (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [1:0] power_mode,
   input wire logic [2:0] unit_sel,
   input wire logic unit_rd,
   input wire logic unit_wr,
   input wire logic [2:0] unit_clk_en,
   input wire logic [2:0] unit_fault,
   input wire logic irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_fault; 1 |=> unit_fault == $past(unit_sel & {3{unit_rd | unit_wr}} & ~unit_clk_en); endproperty
   a_fault: assert property (p_fault) else $error("fault map");
   property p_wdt; unit_sel[0] && unit_rd && !unit_clk_en[0] |=> unit_fault[0]; endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog fault");
   property p_idle; !$past(reg_rd) |-> reg_rdata == 32'h0000_0000; endproperty
   a_idle: assert property (p_idle) else $error("read idle");
   // gate registers only: every reserved bit, 2:0 included, must read zero
   property p_rsvd; $past(reg_rd && (reg_addr == 12'h100 || reg_addr == 12'h110 || reg_addr == 12'h120))
      |-> (reg_rdata & 32'hFEFF_FFB7) == 0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits");
   // write then read of the run register returns only implemented bits
   property p_back; (reg_wr && reg_addr == 12'h100) ##2 (reg_rd && reg_addr == 12'h100)
      |=> reg_rdata == ($past(reg_wdata, 3) & 32'h0100_0048); endproperty
   a_back: assert property (p_back) else $error("read back");
   property p_en; $changed(unit_clk_en) |-> $past(reg_wr, 2) || $past(power_mode, 3) != $past(power_mode, 4); endproperty
   a_en: assert property (p_en) else $error("enable cause");
   property p_rise; $rose(irq) |-> $past(unit_fault) != 0 || $past(reg_wr, 2); endproperty
   a_rise: assert property (p_rise) else $error("irq rise");
   property p_fall; $fell(irq) |-> $past(reg_wr, 2); endproperty
   a_fall: assert property (p_fall) else $error("irq fall");
endmodule // pcg_monitor
bind pcg_top pcg_monitor i_mon (.*);
`default_nettype wire

// file: tb/pcg_units.sv
// Purpose: unit side access model; Assumes: one access per request; Notes: no select when idle
`timescale 1ns/100ps
`default_nettype none
module pcg_units (
   input wire logic [2:0] req,
   input wire logic wr,
   output logic [2:0] unit_sel,
   output logic unit_rd,
   output logic unit_wr
);
   // unit accesses carry one-hot select, direction follows wr
   assign unit_sel = req;
   assign unit_rd = |req & ~wr;
   assign unit_wr = |req & wr;
endmodule // pcg_units
`default_nettype wire

// file: tb/pcg_top_test.sv
// Purpose: register, gating and fault tests; Assumes: 200 MHz clock; Notes: select bit at 0x130
`timescale 1ns/100ps
`default_nettype none
module pcg_top_test;
   logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, wr = 0, unit_rd, unit_wr, irq;
   logic [11:0] reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata;
   logic [1:0] power_mode = 0;
   logic [2:0] req = 0, unit_sel, unit_clk_en, unit_fault;
   int num_errors = 0, check_count = 0;
   always #2.5 ref_clk = ~ref_clk;
   pcg_units i_units (.*);
   pcg_top i_dut (.*);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      num_errors += int'(seen !== exp);
      if (seen !== exp) $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
   endtask
   // one strobe cycle; read data compared in the following cycle
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
      @(posedge ref_clk);
      {reg_wr, reg_rd} <= 2'h0;
      #1 if (!w) check(reg_rdata, d);
   endtask
   task automatic access(input int i, input logic w, input logic [2:0] e);
      @(posedge ref_clk);
      {req, wr} <= {3'h1 << i, w};
      @(posedge ref_clk);
      req <= 3'h0;
      // the fault pulse stands only in the cycle after the access edge
      #1 check(32'(unit_fault), 32'(e));
   endtask
   // mode passes two sync flops before the enables follow
   task automatic settle(input logic [1:0] m, input logic [2:0] e);
      @(posedge ref_clk);
      power_mode <= m;
      repeat (3) @(posedge ref_clk);
      #1 check(32'(unit_clk_en), 32'(e));
   endtask
   task automatic report_and_stop;
      if (num_errors == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #5000 num_errors++;
      report_and_stop();
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 0;
      for (int k = 0; k < 3; k++) bus(0, 12'h100 + 12'(k * 16), 32'h0000_0040);
      access(0, 0, 3'h1);
      access(2, 1, 3'h4);
      bus(1, 12'h144, 32'h0000_0001);
      bus(0, 12'h140, 32'h0000_0005);
      check(32'(irq), 32'h0000_0001);
      bus(1, 12'h140, 32'h0000_0001);
      bus(0, 12'h140, 32'h0000_0004);
      check(32'(irq), 32'h0000_0000);
      bus(0, 12'h1FC, 32'h0000_0000);
      bus(1, 12'h100, 32'hFFFF_FFFF);
      bus(0, 12'h100, 32'h0100_0048);
      bus(1, 12'h110, 32'h0000_0008);
      settle(1, 3'h7);
      bus(1, 12'h130, 32'h0000_0001);
      settle(1, 3'h1);
      settle(2, 3'h2);
      bus(1, 12'h100, 32'h0000_0000);
      settle(0, 3'h0);
      access(1, 1, 3'h2);
      report_and_stop();
   end
endmodule // pcg_top_test
`default_nettype wire
